// ### hdl/pll_path_pkg.sv
// shared constants and carrier types for the pll path select block
package pll_path_pkg;

   // register offsets
   localparam logic [7:0] ADDR_NEAR_INHIBIT = 8'h03;
   localparam logic [7:0] ADDR_DIVIDE_TO_8K_LOCKING_FIRST = 8'h22;
   localparam logic [7:0] ADDR_DIVIDE_TO_8K_LOCKING_LAST  = 8'h28;
   localparam logic [7:0] ADDR_DIFF_TAP     = 8'h61;
   localparam logic [7:0] ADDR_SE_TAP       = 8'h62;
   localparam logic [7:0] ADDR_AUX_FREQ     = 8'h64;
   localparam logic [7:0] ADDR_MULT_CFG     = 8'h65;
   localparam logic [7:0] ADDR_LOCKED_BW    = 8'h67;
   localparam logic [7:0] ADDR_ACQ_BW       = 8'h69;
   localparam logic [7:0] ADDR_DAMPING      = 8'h6b;
   localparam logic [7:0] ADDR_MULTICYCLE   = 8'h74;
   localparam logic [7:0] ADDR_LOWRATE_SRC  = 8'h7a;

   // bit positions and input count
   localparam int NEAR_INHIBIT_BIT = 6;
   localparam int DIVIDE_TO_8K_LOCKING_BIT       = 6;
   localparam int MULT2_SRC_BIT    = 6;
   localparam int MC_EN_BIT        = 6;
   localparam int MC_LOOP_BIT      = 5;
   localparam int LOWRATE_AUX_BIT  = 7;
   localparam int NUM_INPUTS       = 7;
   localparam logic [2:0] LAST_INPUT = 3'h6;

   // reset values and multi-cycle range limit
   localparam logic [7:0] RST_MULT_CFG = 8'h00;
   localparam logic [2:0] RST_DAMPING  = 3'h3;
   localparam logic [3:0] MC_MAX_CODE  = 4'hc;

   // phase arithmetic: 256 counts per unit interval
   localparam int PHASE_W    = 16;
   localparam int PHASE_FRAC = 8;
   localparam int MC_W       = 24;
   localparam int AVG_SHIFT  = 6;
   localparam int AVG_ACC_W  = PHASE_W + AVG_SHIFT;
   localparam logic signed [MC_W-1:0] PHASE_PER_UI = 24'sh000100;

   typedef enum logic [2:0] {
      M1_MAIN_ANALOG  = 3'h0,
      M1_MAIN_DIGITAL = 3'h1,
      M1_12E1         = 3'h2,
      M1_16E1         = 3'h3,
      M1_24DS1        = 3'h4,
      M1_16DS1        = 3'h5
   } mult1Sel_t;

   typedef enum logic [1:0] {
      RATE_12E1  = 2'h0,
      RATE_16E1  = 2'h1,
      RATE_24DS1 = 2'h2,
      RATE_16DS1 = 2'h3
   } rate_t;

   typedef enum logic [1:0] {
      BW_18HZ = 2'h0,
      BW_35HZ = 2'h1,
      BW_70HZ = 2'h2
   } bw_t;

   typedef enum logic [2:0] {
      DAMP_1P2 = 3'h1,
      DAMP_2P5 = 3'h2,
      DAMP_5   = 3'h3,
      DAMP_10  = 3'h4,
      DAMP_20  = 3'h5
   } damp_t;

   typedef enum logic [3:0] {
      TAP_M1_DIV1  = 4'h0,
      TAP_M1_DIV2  = 4'h1,
      TAP_M1_DIV4  = 4'h2,
      TAP_M1_DIV6  = 4'h3,
      TAP_M1_DIV8  = 4'h4,
      TAP_M1_DIV12 = 4'h5,
      TAP_M1_DIV16 = 4'h6,
      TAP_M1_DIV48 = 4'h7,
      TAP_M2_DIV2  = 4'h8,
      TAP_M2_DIV4  = 4'h9,
      TAP_M2_DIV8  = 4'ha,
      TAP_M2_DIV12 = 4'hb,
      TAP_M2_DIV16 = 4'hc,
      TAP_M2_DIV48 = 4'hd,
      TAP_M2_DIV64 = 4'he,
      TAP_LOWRATE  = 4'hf
   } tap_t;

   typedef enum logic [1:0] {
      PFD_DIRECT = 2'h0,
      PFD_HALVE  = 2'h1,
      PFD_TO_8K  = 2'h2
   } pfdDiv_t;

   typedef struct packed {
      logic       en;
      logic       write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } regAccess_t;

   typedef struct packed {
      mult1Sel_t  mult1Sel;
      logic       mainAnalogFb;
      logic       mult2FromLowRate;
      rate_t      mult2Rate;
      logic [2:0] auxFreq;
      tap_t       diffTap;
      tap_t       seTap;
      logic       lowRateFromAux;
   } pathCfg_t;

   typedef struct packed {
      bw_t     bandwidth;
      damp_t   damping;
      pfdDiv_t pfdDiv;
      logic    nearestEdge;
   } loopCfg_t;

endpackage

// ### hdl/phase_average.sv
// averaging low-pass stage between the phase detector and the loop filter
`timescale 1ns/10ps
module phase_average (
   input  wire logic                                  clk_sys,     // system clock
   input  wire logic                                  rst_n,       // sync reset
   input  wire logic                                  sampleValid, // new error sample
   input  wire logic signed [pll_path_pkg::PHASE_W-1:0] sample,    // raw phase error
   output logic signed [pll_path_pkg::PHASE_W-1:0]      average      // filtered error
);

   typedef struct packed {
      logic signed [pll_path_pkg::AVG_ACC_W-1:0] acc;
      logic signed [pll_path_pkg::PHASE_W-1:0]   avg;
   } avgState_t;

   avgState_t st;
   avgState_t next_st;

   // first-order recursive average; shift sets the corner near 100 Hz
   always_comb begin
      next_st = st;
      if (sampleValid) begin
         next_st.acc = st.acc + (pll_path_pkg::AVG_ACC_W'(sample)
                       - (st.acc >>> pll_path_pkg::AVG_SHIFT));
         next_st.avg = pll_path_pkg::PHASE_W'(next_st.acc >>> pll_path_pkg::AVG_SHIFT);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign average = st.avg;

endmodule // phase_average

// ### hdl/pll_path_select.sv
// path selection, loop setting and phase detector control around the digital loops
//
// Functional notes
// - sync pulses always from main loop; one bit picks 2/8 kHz source.
// - source bit 0: second multiplier fed by auxiliary loop at its frequency.
// - source bit 1: low-rate synthesizer feeds second multiplier, two-bit rate.
// - first select codes 000/001: main 77.76 MHz, analog or digital feedback.
// - codes 010..101 route low-rate synthesizer rates to first multiplier.
// - first multiplier never takes the auxiliary loop output.
// - main loop leaves reset using analog feedback.
// - first multiplier /1,/2 differential only; /48 single-ended only.
// - phase error passes a 100 Hz averaging stage before loop filter.
// - acquisition bandwidth 18, 35 or 70 Hz, reset at 70 Hz.
// - locked bandwidth 18, 35 or 70 Hz, independent of acquisition.
// - damping codes 1,2,3 give 1.2, 2.5 and 5 at every bandwidth.
// - codes 4,5: 5 at 18 Hz, 10 at 35 Hz, 10/20 at 70 Hz.
// - direct locking up to 77.76 MHz; 155.52 MHz input halved first.
// - per-input divide-to-8k bit divides its own input to 8 kHz.
// - nearest-edge capture once locked with multi-cycle detector off.
// - inhibit bit keeps frequency-locking capture permanently.
// - multi-cycle detector enable bit and range code, 1 to 8191 UI.
// - loop-use bit high passes full value, low caps at 360 degrees.
// - multi-cycle detector keeps tracking final phase regardless of loop-use bit.
`timescale 1ns/10ps
module pll_path_select (
   input  wire logic                                  clk_sys,     // system clock
   input  wire logic                                  rst_n,       // sync reset
   input  wire pll_path_pkg::regAccess_t              regAccess,   // register access
   output logic [7:0]                                 regRdData,   // read data
   input  wire logic                                  phaseLocked, // lock detectors agree
   input  wire logic [2:0]                            selInput,    // selected input
   input  wire logic                                  ref155,      // input is 155.52 MHz
   input  wire logic                                  pfdValid,    // detector sample
   input  wire logic signed [pll_path_pkg::PHASE_W-1:0] pfdError,  // detector error
   input  wire logic                                  mcValid,     // multi-cycle sample
   input  wire logic signed [pll_path_pkg::MC_W-1:0]  mcPhase,     // multi-cycle phase
   output pll_path_pkg::pathCfg_t                     pathCfg,     // mux and tap setup
   output pll_path_pkg::loopCfg_t                     loopCfg,     // loop settings
   output logic signed [pll_path_pkg::MC_W-1:0]       loopPhase,   // phase into loop
   output logic signed [pll_path_pkg::MC_W-1:0]       mcHeld,      // tracked position
   output logic signed [pll_path_pkg::PHASE_W-1:0]    filtError    // averaged error
);

   typedef struct packed {
      logic [7:0]                             multCfg;
      logic [7:0]                             lowRateReg;
      logic [7:0]                             auxFreqReg;
      logic [7:0]                             inhibitReg;
      logic [7:0]                             mcReg;
      pll_path_pkg::tap_t                     diffTap;
      pll_path_pkg::tap_t                     seTap;
      pll_path_pkg::bw_t                      lockedBw;
      pll_path_pkg::bw_t                      acqBw;
      logic [2:0]                             dampCode;
      logic [pll_path_pkg::NUM_INPUTS-1:0]    divide_to_8k_locking;
      pll_path_pkg::pathCfg_t                 path;
      pll_path_pkg::loopCfg_t                 loop;
      logic signed [pll_path_pkg::MC_W-1:0]   held;
      logic signed [pll_path_pkg::MC_W-1:0]   loopPh;
      logic [7:0]                             rdData;
   } state_t;

   state_t st;
   state_t next_st;

   function automatic logic signed [pll_path_pkg::MC_W-1:0] clampPhase(
      input logic signed [pll_path_pkg::MC_W-1:0] v,
      input logic signed [pll_path_pkg::MC_W-1:0] lim);
      if (v > lim) begin
         return lim;
      end else if (v < -lim) begin
         return -lim;
      end
      return v;
   endfunction

   // range grows as 2^(code+1)-1 unit intervals
   function automatic logic signed [pll_path_pkg::MC_W-1:0] mcLimit(input logic [3:0] code);
      logic [pll_path_pkg::MC_W-1:0] ui;
      ui = (pll_path_pkg::MC_W'(1) << (code + 4'h1)) - pll_path_pkg::MC_W'(1);
      return signed'(ui << pll_path_pkg::PHASE_FRAC);
   endfunction

   function automatic pll_path_pkg::damp_t dampMap(input pll_path_pkg::bw_t bw,
                                                   input logic [2:0] code);
      pll_path_pkg::damp_t d;
      d = pll_path_pkg::DAMP_5;
      unique case (code)
         3'h1: d = pll_path_pkg::DAMP_1P2;
         3'h2: d = pll_path_pkg::DAMP_2P5;
         3'h4: d = (bw == pll_path_pkg::BW_18HZ) ? pll_path_pkg::DAMP_5
                                                 : pll_path_pkg::DAMP_10;
         3'h5: begin
            if (bw == pll_path_pkg::BW_18HZ) begin
               d = pll_path_pkg::DAMP_5;
            end else if (bw == pll_path_pkg::BW_35HZ) begin
               d = pll_path_pkg::DAMP_10;
            end else begin
               d = pll_path_pkg::DAMP_20;
            end
         end
         default: d = pll_path_pkg::DAMP_5;
      endcase
      return d;
   endfunction

   logic [2:0] lock8kIdx;
   assign lock8kIdx = 3'(regAccess.addr - pll_path_pkg::ADDR_DIVIDE_TO_8K_LOCKING_FIRST);

   always_comb begin
      pll_path_pkg::bw_t activeBw;
      logic               wr;
      next_st = st;
      wr      = regAccess.en && regAccess.write;
      activeBw = phaseLocked ? st.lockedBw : st.acqBw;

      if (wr) begin
         unique case (regAccess.addr)
            pll_path_pkg::ADDR_MULT_CFG: begin
               next_st.multCfg = regAccess.wdata;
               // codes above 101 would name no legal source; keep the old one
               if (regAccess.wdata[2:0] > pll_path_pkg::M1_16DS1) begin
                  next_st.multCfg[2:0] = st.multCfg[2:0];
               end
            end
            pll_path_pkg::ADDR_DIFF_TAP: begin
               if (regAccess.wdata[3:0] != pll_path_pkg::TAP_M1_DIV48) begin
                  next_st.diffTap = pll_path_pkg::tap_t'(regAccess.wdata[3:0]);
               end
            end
            pll_path_pkg::ADDR_SE_TAP: begin
               if (regAccess.wdata[3:0] != pll_path_pkg::TAP_M1_DIV1 &&
                   regAccess.wdata[3:0] != pll_path_pkg::TAP_M1_DIV2) begin
                  next_st.seTap = pll_path_pkg::tap_t'(regAccess.wdata[3:0]);
               end
            end
            pll_path_pkg::ADDR_LOCKED_BW: begin
               if (regAccess.wdata[1:0] <= pll_path_pkg::BW_70HZ) begin
                  next_st.lockedBw = pll_path_pkg::bw_t'(regAccess.wdata[1:0]);
               end
            end
            pll_path_pkg::ADDR_ACQ_BW: begin
               if (regAccess.wdata[1:0] <= pll_path_pkg::BW_70HZ) begin
                  next_st.acqBw = pll_path_pkg::bw_t'(regAccess.wdata[1:0]);
               end
            end
            pll_path_pkg::ADDR_DAMPING: begin
               if (regAccess.wdata[2:0] >= pll_path_pkg::DAMP_1P2 &&
                   regAccess.wdata[2:0] <= pll_path_pkg::DAMP_20) begin
                  next_st.dampCode = regAccess.wdata[2:0];
               end
            end
            pll_path_pkg::ADDR_MULTICYCLE: begin
               next_st.mcReg = regAccess.wdata;
               if (regAccess.wdata[3:0] > pll_path_pkg::MC_MAX_CODE) begin
                  next_st.mcReg[3:0] = pll_path_pkg::MC_MAX_CODE;
               end
            end
            pll_path_pkg::ADDR_AUX_FREQ:     next_st.auxFreqReg = regAccess.wdata;
            pll_path_pkg::ADDR_LOWRATE_SRC:  next_st.lowRateReg = regAccess.wdata;
            pll_path_pkg::ADDR_NEAR_INHIBIT: next_st.inhibitReg = regAccess.wdata;
            default: begin
               if (regAccess.addr >= pll_path_pkg::ADDR_DIVIDE_TO_8K_LOCKING_FIRST &&
                   regAccess.addr <= pll_path_pkg::ADDR_DIVIDE_TO_8K_LOCKING_LAST) begin
                  next_st.divide_to_8k_locking[lock8kIdx] =
                     regAccess.wdata[pll_path_pkg::DIVIDE_TO_8K_LOCKING_BIT];
               end
            end
         endcase
      end

      // read port: unmapped offsets answer zero
      next_st.rdData = 8'h00;
      if (regAccess.en && !regAccess.write) begin
         unique case (regAccess.addr)
            pll_path_pkg::ADDR_MULT_CFG:     next_st.rdData = st.multCfg;
            pll_path_pkg::ADDR_DIFF_TAP:     next_st.rdData = {4'h0, st.diffTap};
            pll_path_pkg::ADDR_SE_TAP:       next_st.rdData = {4'h0, st.seTap};
            pll_path_pkg::ADDR_LOCKED_BW:    next_st.rdData = {6'h00, st.lockedBw};
            pll_path_pkg::ADDR_ACQ_BW:       next_st.rdData = {6'h00, st.acqBw};
            pll_path_pkg::ADDR_DAMPING:      next_st.rdData = {5'h00, st.dampCode};
            pll_path_pkg::ADDR_MULTICYCLE:   next_st.rdData = st.mcReg;
            pll_path_pkg::ADDR_AUX_FREQ:     next_st.rdData = st.auxFreqReg;
            pll_path_pkg::ADDR_LOWRATE_SRC:  next_st.rdData = st.lowRateReg;
            pll_path_pkg::ADDR_NEAR_INHIBIT: next_st.rdData = st.inhibitReg;
            default: begin
               if (regAccess.addr >= pll_path_pkg::ADDR_DIVIDE_TO_8K_LOCKING_FIRST &&
                   regAccess.addr <= pll_path_pkg::ADDR_DIVIDE_TO_8K_LOCKING_LAST) begin
                  next_st.rdData[pll_path_pkg::DIVIDE_TO_8K_LOCKING_BIT] = st.divide_to_8k_locking[lock8kIdx];
               end
            end
         endcase
      end

      // multiplexer routing follows the stored configuration
      next_st.path.mult1Sel = pll_path_pkg::mult1Sel_t'(st.multCfg[2:0]);
      next_st.path.mainAnalogFb = (st.multCfg[2:0] != pll_path_pkg::M1_MAIN_DIGITAL);
      next_st.path.mult2FromLowRate = st.multCfg[pll_path_pkg::MULT2_SRC_BIT];
      next_st.path.mult2Rate = pll_path_pkg::rate_t'(st.multCfg[5:4]);
      next_st.path.auxFreq = st.auxFreqReg[2:0];
      next_st.path.diffTap = st.diffTap;
      next_st.path.seTap = st.seTap;
      // sync pulses have no selector: they are always wired to the main loop
      next_st.path.lowRateFromAux = st.lowRateReg[pll_path_pkg::LOWRATE_AUX_BIT];

      next_st.loop.bandwidth = activeBw;
      next_st.loop.damping = dampMap(activeBw, st.dampCode);
      if (selInput <= pll_path_pkg::LAST_INPUT && st.divide_to_8k_locking[selInput]) begin
         next_st.loop.pfdDiv = pll_path_pkg::PFD_TO_8K;
      end else if (ref155) begin
         next_st.loop.pfdDiv = pll_path_pkg::PFD_HALVE;
      end else begin
         next_st.loop.pfdDiv = pll_path_pkg::PFD_DIRECT;
      end
      next_st.loop.nearestEdge = !st.mcReg[pll_path_pkg::MC_EN_BIT] && phaseLocked
                                 && !st.inhibitReg[pll_path_pkg::NEAR_INHIBIT_BIT];

      // tracking continues whatever the loop-use bit says
      if (mcValid && st.mcReg[pll_path_pkg::MC_EN_BIT]) begin
         next_st.held = clampPhase(mcPhase, mcLimit(st.mcReg[3:0]));
      end
      next_st.loopPh = st.mcReg[pll_path_pkg::MC_LOOP_BIT] ? st.held
                       : clampPhase(st.held, pll_path_pkg::PHASE_PER_UI);
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st          <= '0;
         st.multCfg  <= pll_path_pkg::RST_MULT_CFG;
         st.lockedBw <= pll_path_pkg::BW_70HZ;
         st.acqBw    <= pll_path_pkg::BW_70HZ;
         st.dampCode <= pll_path_pkg::RST_DAMPING;
         st.seTap    <= pll_path_pkg::TAP_M1_DIV4;
         st.path.mainAnalogFb <= 1'b1;
         st.path.seTap        <= pll_path_pkg::TAP_M1_DIV4;
         st.loop.bandwidth    <= pll_path_pkg::BW_70HZ;
         st.loop.damping      <= pll_path_pkg::DAMP_5;
      end else begin
         st <= next_st;
      end
   end

   phase_average phase_average_i (
      .clk_sys     (clk_sys),
      .rst_n       (rst_n),
      .sampleValid (pfdValid),
      .sample      (pfdError),
      .average     (filtError)
   );

   assign regRdData = st.rdData;
   assign pathCfg   = st.path;
   assign loopCfg   = st.loop;
   assign loopPhase = st.loopPh;
   assign mcHeld    = st.held;

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   a_lowrate_src_bit: assert property (regAccess.en && regAccess.write &&
      regAccess.addr == pll_path_pkg::ADDR_LOWRATE_SRC |-> ##2
      pathCfg.lowRateFromAux == $past(regAccess.wdata[pll_path_pkg::LOWRATE_AUX_BIT], 2))
      else $error("low-rate source does not follow its bit");
   a_mult1_no_aux: assert property (pathCfg.mult1Sel <= pll_path_pkg::M1_16DS1)
      else $error("first multiplier select out of legal range");
   a_digital_fb_code: assert property (regAccess.en && regAccess.write &&
      regAccess.addr == pll_path_pkg::ADDR_MULT_CFG &&
      regAccess.wdata[2:0] == pll_path_pkg::M1_MAIN_DIGITAL |-> ##2 !pathCfg.mainAnalogFb)
      else $error("digital feedback code not applied");
   a_reset_analog_fb: assert property ($past(!rst_n) |-> pathCfg.mainAnalogFb
      && st.acqBw == pll_path_pkg::BW_70HZ)
      else $error("reset defaults wrong");
   a_tap_port_legal: assert property (pathCfg.diffTap != pll_path_pkg::TAP_M1_DIV48
      && pathCfg.seTap != pll_path_pkg::TAP_M1_DIV1
      && pathCfg.seTap != pll_path_pkg::TAP_M1_DIV2)
      else $error("divider tap on wrong port");
   a_nearest_edge_on: assert property (!st.mcReg[pll_path_pkg::MC_EN_BIT] && phaseLocked
      && !st.inhibitReg[pll_path_pkg::NEAR_INHIBIT_BIT] |=> loopCfg.nearestEdge)
      else $error("nearest edge not selected");
   a_nearest_inhibit: assert property (st.inhibitReg[pll_path_pkg::NEAR_INHIBIT_BIT]
      |=> !loopCfg.nearestEdge)
      else $error("nearest edge selected while inhibited");
   a_damp_top: assert property (phaseLocked && st.lockedBw == pll_path_pkg::BW_70HZ
      && st.dampCode == 3'h5 |=> loopCfg.damping == pll_path_pkg::DAMP_20)
      else $error("damping 20 not selected");
   a_divide_to_8k_locking_div: assert property (selInput <= pll_path_pkg::LAST_INPUT
      && st.divide_to_8k_locking[selInput] |=> loopCfg.pfdDiv == pll_path_pkg::PFD_TO_8K)
      else $error("divide-to-8k not applied");
   a_loop_cap: assert property (!st.mcReg[pll_path_pkg::MC_LOOP_BIT] |=>
      loopPhase <= pll_path_pkg::PHASE_PER_UI && loopPhase >= -pll_path_pkg::PHASE_PER_UI)
      else $error("loop phase exceeds one cycle");
   a_analog_fb_code: assert property (regAccess.en && regAccess.write &&
      regAccess.addr == pll_path_pkg::ADDR_MULT_CFG &&
      regAccess.wdata[2:0] == pll_path_pkg::M1_MAIN_ANALOG |-> ##2 pathCfg.mainAnalogFb)
      else $error("analog feedback code not applied");
   a_mult2_source: assert property (regAccess.en && regAccess.write &&
      regAccess.addr == pll_path_pkg::ADDR_MULT_CFG |-> ##2
      pathCfg.mult2FromLowRate == $past(regAccess.wdata[pll_path_pkg::MULT2_SRC_BIT], 2)
      && pathCfg.mult2Rate == $past(regAccess.wdata[5:4], 2))
      else $error("second multiplier source or rate wrong");
   a_damp_fixed: assert property (st.dampCode >= pll_path_pkg::DAMP_1P2
      && st.dampCode <= pll_path_pkg::DAMP_5 |=> loopCfg.damping == $past(st.dampCode))
      else $error("fixed damping code not applied");
   a_locked_bw: assert property (phaseLocked |=>
      loopCfg.bandwidth == $past(st.lockedBw))
      else $error("locked bandwidth not in use");
   a_acq_bw: assert property (!phaseLocked |=>
      loopCfg.bandwidth == $past(st.acqBw))
      else $error("acquisition bandwidth not in use");
   a_halve_155: assert property (ref155 && !(selInput <= pll_path_pkg::LAST_INPUT
      && st.divide_to_8k_locking[selInput]) |=> loopCfg.pfdDiv == pll_path_pkg::PFD_HALVE)
      else $error("high-rate input not halved");

endmodule // pll_path_select

// ### tb/pll_path_select_tb.sv
// self-checking bench for the pll path select block
`timescale 1ns/10ps
module pll_path_select_tb;
   logic                       clk_sys;
   logic                       rst_n;
   pll_path_pkg::regAccess_t   regAccess;
   logic [7:0]                 regRdData;
   logic                       phaseLocked;
   logic [2:0]                 selInput;
   logic                       ref155;
   logic                       pfdValid;
   logic signed [15:0]         pfdError;
   logic                       mcValid;
   logic signed [23:0]         mcPhase;
   pll_path_pkg::pathCfg_t     pathCfg;
   pll_path_pkg::loopCfg_t     loopCfg;
   logic signed [23:0]         loopPhase;
   logic signed [23:0]         mcHeld;
   logic signed [15:0]         filtError;
   int                         bad_count = 0;
   int                         n_compared = 0;

   pll_path_select pll_path_select_i (
      .clk_sys(clk_sys), .rst_n(rst_n), .regAccess(regAccess), .regRdData(regRdData),
      .phaseLocked(phaseLocked), .selInput(selInput), .ref155(ref155),
      .pfdValid(pfdValid), .pfdError(pfdError), .mcValid(mcValid), .mcPhase(mcPhase),
      .pathCfg(pathCfg), .loopCfg(loopCfg), .loopPhase(loopPhase), .mcHeld(mcHeld),
      .filtError(filtError));

   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // outputs settle one edge after the taking edge; two spare cycles for derived fields
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regAccess <= '{en: 1'b1, write: 1'b1, addr: a, wdata: d};
      @(negedge clk_sys);
      regAccess.en <= 1'b0;
      repeat (3) @(negedge clk_sys);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
      regAccess <= '{en: 1'b1, write: 1'b0, addr: a, wdata: 8'h00};
      @(negedge clk_sys);
      regAccess.en <= 1'b0;
      chk(regRdData, exp, what);
      // spare cycle so a following access never re-drives the bus in this step
      @(negedge clk_sys);
   endtask

   task automatic mcs(input logic signed [23:0] p);
      mcValid <= 1'b1;
      mcPhase <= p;
      @(negedge clk_sys);
      mcValid <= 1'b0;
      repeat (3) @(negedge clk_sys);
   endtask

   task automatic end_of_test();
      $display("compared %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   // whole sequence needs well under 2000 cycles
   initial begin
      #200000;
      bad_count++;
      end_of_test();
   end

   initial begin
      rst_n = 1'b0;
      regAccess = '0;
      phaseLocked = 1'b0;
      selInput = 3'h7;
      ref155 = 1'b0;
      pfdValid = 1'b0;
      pfdError = 16'sh0000;
      mcValid = 1'b0;
      mcPhase = 24'sh000000;
      repeat (5) @(negedge clk_sys);
      rst_n <= 1'b1;
      repeat (2) @(negedge clk_sys);
      chk(pathCfg.mainAnalogFb, 24'h1, "reset feedback");
      chk(loopCfg.bandwidth, pll_path_pkg::BW_70HZ, "reset bandwidth");
      for (int c = 0; c < 6; c++) begin
         wr(pll_path_pkg::ADDR_MULT_CFG, 8'(c));
         chk(pathCfg.mult1Sel, 24'(c), "first_multiplier_input_select code");
         if (c < 2) chk(pathCfg.mainAnalogFb, 24'(c == 0), "feedback kind");
      end
      // codes 6 and 7 would name the auxiliary loop: must be dropped
      wr(pll_path_pkg::ADDR_MULT_CFG, 8'h06);
      chk(pathCfg.mult1Sel, pll_path_pkg::M1_16DS1, "first_multiplier_input_select illegal");
      rd(pll_path_pkg::ADDR_MULT_CFG, 8'h05, "mux cfg readback");
      for (int r = 0; r < 4; r++) begin
         wr(pll_path_pkg::ADDR_MULT_CFG, 8'h40 | 8'(r << 4) | 8'(r + 2));
         chk(pathCfg.mult2FromLowRate, 24'h1, "second_multiplier_input_select lowrate");
         chk(pathCfg.mult2Rate, 24'(r), "second_multiplier_input_select rate");
      end
      wr(pll_path_pkg::ADDR_AUX_FREQ, 8'h05);
      wr(pll_path_pkg::ADDR_MULT_CFG, 8'h00);
      chk(pathCfg.mult2FromLowRate, 24'h0, "second_multiplier_input_select aux");
      chk(pathCfg.auxFreq, 24'h5, "aux freq");
      for (int b = 1; b >= 0; b--) begin
         wr(pll_path_pkg::ADDR_LOWRATE_SRC, {b[0], 7'h00});
         chk(pathCfg.lowRateFromAux, 24'(b), "lowrate source");
      end
      wr(pll_path_pkg::ADDR_DIFF_TAP, 8'h00);
      wr(pll_path_pkg::ADDR_DIFF_TAP, 8'h07);
      chk(pathCfg.diffTap, pll_path_pkg::TAP_M1_DIV1, "diff tap");
      wr(pll_path_pkg::ADDR_SE_TAP, 8'h07);
      wr(pll_path_pkg::ADDR_SE_TAP, 8'h01);
      chk(pathCfg.seTap, pll_path_pkg::TAP_M1_DIV48, "se tap");
      wr(pll_path_pkg::ADDR_ACQ_BW, 8'h00);
      wr(pll_path_pkg::ADDR_ACQ_BW, 8'h03);
      wr(pll_path_pkg::ADDR_LOCKED_BW, 8'h01);
      chk(loopCfg.bandwidth, pll_path_pkg::BW_18HZ, "acq bandwidth");
      phaseLocked <= 1'b1;
      repeat (3) @(negedge clk_sys);
      chk(loopCfg.bandwidth, pll_path_pkg::BW_35HZ, "locked bandwidth");
      chk(loopCfg.nearestEdge, 24'h1, "nearest edge");
      for (int b = 0; b < 3; b++) begin
         wr(pll_path_pkg::ADDR_LOCKED_BW, 8'(b));
         for (int c = 1; c < 6; c++) begin
            wr(pll_path_pkg::ADDR_DAMPING, 8'(c));
            chk(loopCfg.damping, 24'((c < 4) ? c : (b == 0) ? 3 : (b == 1) ? 4 : c), "damp");
         end
      end
      wr(pll_path_pkg::ADDR_NEAR_INHIBIT, 8'h40);
      chk(loopCfg.nearestEdge, 24'h0, "inhibit");
      wr(pll_path_pkg::ADDR_NEAR_INHIBIT, 8'h00);
      selInput <= 3'h2;
      ref155 <= 1'b1;
      wr(pll_path_pkg::ADDR_DIVIDE_TO_8K_LOCKING_FIRST + 8'h02, 8'h40);
      chk(loopCfg.pfdDiv, pll_path_pkg::PFD_TO_8K, "to 8k");
      wr(pll_path_pkg::ADDR_DIVIDE_TO_8K_LOCKING_FIRST + 8'h02, 8'h00);
      chk(loopCfg.pfdDiv, pll_path_pkg::PFD_HALVE, "halve");
      ref155 <= 1'b0;
      repeat (3) @(negedge clk_sys);
      chk(loopCfg.pfdDiv, pll_path_pkg::PFD_DIRECT, "direct");
      wr(pll_path_pkg::ADDR_MULTICYCLE, 8'h4d);
      rd(pll_path_pkg::ADDR_MULTICYCLE, 8'h4c, "range clamp");
      chk(loopCfg.nearestEdge, 24'h0, "mc blocks edge");
      mcs(-24'sh0003e8);
      chk(mcHeld, -24'sh0003e8, "held capped");
      chk(loopPhase, -24'sh000100, "capped phase");
      wr(pll_path_pkg::ADDR_MULTICYCLE, 8'h6c);
      mcs(24'sh0003e8);
      chk(mcHeld, 24'sh0003e8, "held full");
      chk(loopPhase, 24'sh0003e8, "full phase");
      pfdError <= 16'sh4000;
      pfdValid <= 1'b1;
      @(negedge clk_sys);
      pfdValid <= 1'b0;
      @(negedge clk_sys);
      chk(24'(filtError > 16'sh0000 && filtError < 16'sh4000), 24'h1, "averaged");
      end_of_test();
   end
endmodule // pll_path_select_tb
